// file: rtl/flash_self_program_sequencer.sv
// Self-programming sequencer: arm-then-execute control, page buffer, erase/write, lock and fuse reads.
// Assumes a core that reports store/load program instructions through the instruction register,
// and an EEPROM block reporting its write-active level on the same clock.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer #(
  parameter int PAGE_WORDS = 32,
  parameter int PAGE_BITS = 7,
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES,
  parameter logic [PAGE_BITS-1:0] HALT_FIRST_PAGE = 7'h60,
  parameter logic [7:0] FUSE_LOW = 8'he1,
  parameter logic [7:0] FUSE_HIGH = 8'hd9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic eeprom_write_active_i,
  output logic core_halt_o,
  output logic section_read_block_o,
  output logic ready_irq_o,
  output logic erase_pulse_o,
  output logic write_pulse_o,
  output logic [PAGE_BITS-1:0] prog_page_o
);
  localparam int WB = $clog2(PAGE_WORDS);
  initial begin
    if (PROG_CYCLES < 8 || PAGE_WORDS < 2) begin
      $error("flash_self_program_sequencer: unsupported parameters");
    end
  end

  flash_seq_pkg::bus_req_t req;
  assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};

  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic [7:0] result_q;
  logic [7:0] lock_q;
  logic [4:0] cmd_q;
  logic irq_en_q;
  logic busy_flag_q;
  logic [2:0] win_q;
  logic [31:0] prog_cnt_q;
  logic [PAGE_BITS-1:0] page_q;
  logic page_halt_q;
  logic prog_erase_q;
  logic ack_q;
  flash_seq_pkg::seq_state_t state_q;

  // Bus decode: one word per register, single registered ack one cycle after the request.
  wire bus_req = cyc_i && stb_i && !ack_q;
  wire bus_wr = bus_req && req.we;
  wire wr_ctrl = bus_wr && req.adr == flash_seq_pkg::ADDR_CTRL && req.sel[0];
  wire wr_ptr = bus_wr && req.adr == flash_seq_pkg::ADDR_PTR;
  wire wr_data = bus_wr && req.adr == flash_seq_pkg::ADDR_DATA;
  wire wr_insn = bus_wr && req.adr == flash_seq_pkg::ADDR_INSN && req.sel[0];
  wire store_insn = wr_insn && req.dat[0];
  wire load_insn = wr_insn && req.dat[1];

  wire prog_active = state_q == flash_seq_pkg::ST_PROG;
  wire armed = state_q == flash_seq_pkg::ST_ARMED;
  // The EEPROM interlock refuses the arm write itself so no command can start.
  wire arm_ok = !prog_active && !eeprom_write_active_i;
  wire [4:0] new_cmd = req.dat[4:0];
  wire known_cmd = new_cmd == flash_seq_pkg::CMD_ERASE || new_cmd == flash_seq_pkg::CMD_WRITE
    || new_cmd == flash_seq_pkg::CMD_LOCK || new_cmd == flash_seq_pkg::CMD_REEN
    || new_cmd == flash_seq_pkg::CMD_LOAD;
  wire arm = wr_ctrl && arm_ok && known_cmd;

  wire win_open = armed && win_q != 3'h0;
  wire do_store = store_insn && win_open && !eeprom_write_active_i;
  wire do_erase = do_store && cmd_q == flash_seq_pkg::CMD_ERASE;
  wire do_write = do_store && cmd_q == flash_seq_pkg::CMD_WRITE;
  wire do_lock = do_store && cmd_q == flash_seq_pkg::CMD_LOCK;
  wire do_reen = do_store && cmd_q == flash_seq_pkg::CMD_REEN;
  wire do_load = do_store && cmd_q == flash_seq_pkg::CMD_LOAD;
  wire lock_read_window = win_open && cmd_q == flash_seq_pkg::CMD_LOCK
    && (flash_seq_pkg::STORE_WINDOW - win_q) < flash_seq_pkg::LOAD_WINDOW;
  wire do_lpm = load_insn && lock_read_window && !eeprom_write_active_i;
  wire win_expire = armed && win_q == 3'h1 && !do_store && !do_lpm;

  wire [PAGE_BITS-1:0] ptr_page = ptr_q[WB+PAGE_BITS:WB+1];
  wire [WB-1:0] ptr_word = ptr_q[WB:1];
  wire ptr_halt = ptr_page >= HALT_FIRST_PAGE;
  wire prog_done = prog_active && prog_cnt_q == 32'h1;
  wire buf_any;
  wire [15:0] buf_word;
  wire buf_word_valid;
  wire buf_clear = (prog_done && !prog_erase_q) || do_reen
    || (eeprom_write_active_i && buf_any);

  function automatic logic [7:0] special_byte(input logic [15:0] p, input logic [7:0] locks);
    if (p == flash_seq_pkg::PTR_LOCK) begin
      special_byte = locks;
    end else if (p == flash_seq_pkg::PTR_FUSE_LO) begin
      special_byte = FUSE_LOW;
    end else if (p == flash_seq_pkg::PTR_FUSE_HI) begin
      special_byte = FUSE_HIGH;
    end else begin
      special_byte = 8'hff;
    end
  endfunction : special_byte

  page_buffer #(.WORDS(PAGE_WORDS)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(buf_clear),
    .load_i(do_load && !buf_clear),
    .load_idx_i(ptr_word),
    .load_data_i(data_q),
    .rd_idx_i(ptr_word),
    .rd_data_o(buf_word),
    .rd_valid_o(buf_word_valid),
    .any_valid_o(buf_any)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= flash_seq_pkg::ST_IDLE;
      cmd_q <= 5'h00;
      win_q <= 3'h0;
    end else begin
      case (state_q)
        flash_seq_pkg::ST_IDLE, flash_seq_pkg::ST_DONE: begin
          if (arm) begin
            state_q <= flash_seq_pkg::ST_ARMED;
            cmd_q <= new_cmd;
            win_q <= flash_seq_pkg::STORE_WINDOW;
          end else begin
            state_q <= flash_seq_pkg::ST_IDLE;
          end
        end
        flash_seq_pkg::ST_ARMED: begin
          if (do_erase || do_write) begin
            state_q <= flash_seq_pkg::ST_PROG;
          end else if (do_store || do_lpm || win_expire) begin
            state_q <= flash_seq_pkg::ST_IDLE;
            cmd_q <= 5'h00;
          end else begin
            win_q <= win_q - 3'h1;
          end
        end
        flash_seq_pkg::ST_PROG: begin
          if (prog_done) begin
            state_q <= flash_seq_pkg::ST_DONE;
            cmd_q <= 5'h00;
          end
        end
        default: begin
          state_q <= flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_cnt_q <= 32'h0;
      page_q <= '0;
      page_halt_q <= 1'b0;
      prog_erase_q <= 1'b0;
    end else if (do_erase || do_write) begin
      prog_cnt_q <= 32'(PROG_CYCLES);
      page_q <= ptr_page;
      page_halt_q <= ptr_halt;
      prog_erase_q <= do_erase;
    end else if (prog_active) begin
      prog_cnt_q <= prog_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_flag_q <= 1'b0;
    end else if ((do_erase || do_write) && !ptr_halt) begin
      busy_flag_q <= 1'b1;
    end else if (do_reen || do_load) begin
      busy_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 16'h0000;
      data_q <= 16'h0000;
      irq_en_q <= 1'b0;
      lock_q <= flash_seq_pkg::LOCK_RESET;
      result_q <= 8'h00;
    end else begin
      if (wr_ptr) begin
        ptr_q <= req.dat[15:0];
      end
      if (wr_data) begin
        data_q <= req.dat[15:0];
      end
      if (wr_ctrl) begin
        irq_en_q <= req.dat[flash_seq_pkg::BIT_IRQ_EN];
      end
      if (do_lock) begin
        lock_q <= lock_q & {2'b11, data_q[5:2], 2'b11};
      end
      if (do_lpm) begin
        result_q <= special_byte(ptr_q, lock_q);
      end
    end
  end

  wire store_en = armed || prog_active;
  wire [7:0] ctrl_rd = {irq_en_q, busy_flag_q, 1'b0, cmd_q & {5{store_en}}};
  wire [31:0] rd_mux =
    req.adr == flash_seq_pkg::ADDR_CTRL ? {24'h0, ctrl_rd} :
    req.adr == flash_seq_pkg::ADDR_PTR ? {16'h0, ptr_q} :
    req.adr == flash_seq_pkg::ADDR_DATA ? {16'h0, data_q} :
    req.adr == flash_seq_pkg::ADDR_RESULT ? {24'h0, result_q} :
    req.adr == flash_seq_pkg::ADDR_STATUS ? {30'h0, state_q} :
    req.adr == flash_seq_pkg::ADDR_LOCKS ? {24'h0, lock_q} :
    req.adr == flash_seq_pkg::ADDR_BUFRD ? {15'h0, buf_word_valid, buf_word} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_q <= bus_req;
      dat_o <= bus_req && !req.we ? rd_mux : 32'h0;
    end
  end

  assign ack_o = ack_q;
  assign core_halt_o = prog_active && page_halt_q;
  assign section_read_block_o = busy_flag_q;
  assign ready_irq_o = irq_en_q && !store_en;
  assign erase_pulse_o = do_erase;
  assign write_pulse_o = do_write;
  assign prog_page_o = page_q;

  // An arm that sees no store for its whole window.
  sequence s_arm_unused;
    arm ##1 (!do_store)[*4];
  endsequence

  // A load on the last armed cycle comes too late to read fuse or lock bytes.
  sequence s_late_lock_load;
    armed && cmd_q == flash_seq_pkg::CMD_LOCK && win_q == 3'h1 && load_insn;
  endsequence

  a_store_window: assert property (@(posedge clk_i) disable iff (rst_i)
    s_arm_unused |=> !armed) else $error("arm outlived four cycles");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && req.dat[flash_seq_pkg::BIT_IRQ_EN] && !arm && !armed && !prog_active) |=> ready_irq_o)
    else $error("irq not raised");
  a_busy_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_erase && !ptr_halt) |=> section_read_block_o) else $error("busy not set");
  a_halt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_write && ptr_halt) |=> core_halt_o [*8]) else $error("halt dropped");
  a_page_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_active && !$rose(prog_active) |-> $stable(prog_page_o)) else $error("page moved");
  a_eeprom_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (eeprom_write_active_i && wr_ctrl && !armed && !prog_active) |=> !armed && !erase_pulse_o && !write_pulse_o)
    else $error("arm taken during eeprom write");
  a_bad_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !known_cmd && !armed && !prog_active) |=> !armed) else $error("bad cmd armed");
  a_lock_only_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_q & ~$past(lock_q)) == 8'h00) else $error("lock bit unprogrammed");
  a_reen_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    do_reen |=> !section_read_block_o) else $error("busy kept");
  a_done_release: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_done |=> !store_en) else $error("store enable held after programming");
  a_write_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (prog_done && !prog_erase_q) |=> !buf_any) else $error("buffer kept after page write");
  a_eeprom_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    (eeprom_write_active_i && buf_any) |=> !buf_any) else $error("buffer kept during eeprom write");
  a_late_lock_load: assert property (@(posedge clk_i) disable iff (rst_i)
    s_late_lock_load |=> $stable(result_q) && !armed) else $error("late lock read taken");
endmodule : flash_self_program_sequencer
`default_nettype wire

// file: rtl/flash_seq_pkg.sv
// Constants, types and register map of the self-programming flash sequencer.
// Assumes one 50 MHz clock and a classic Wishbone slave with 32-bit data.
// How it works
// - Buffer words load singly, in any order.
// - Arm pattern X0000011 then store within four cycles erases the pointer's page.
// - Erase or write to the halting section stalls the core throughout.
// - Arm 00000001 then store writes the data pair into the pointer's buffer word.
// - Buffer clears after page write, on read re-enable, and on reset.
// - An EEPROM write during page loading discards the loaded buffer data.
// - Arm X0000101 then store programs the buffer into the pointer's page.
// - Ready interrupt holds while enabled and store enable is clear.
// - Erase or write to the concurrent section blocks its reads and sets busy.
// - Arm X0001001 then store programs lock bits whose data bits 5..2 are zero.
// - Lock programming blocks neither section.
// - EEPROM write blocks all self-programming and all fuse or lock reads.
// - Lock arm with pointer 0x0001 then load within three cycles returns lock byte.
// - Lock arm self-clears after the read or after four idle cycles; its read window closes after three.
// - Lock arm then load returns low fuse for 0x0000, high fuse for 0x0003.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
// - Store enable clears after a store or four idle cycles; held during erase/write.
// - Busy flag clears on read re-enable after completion or when loading begins.
// - Other low five control patterns have no effect.
// - The page address is latched when erase or write starts.
package flash_seq_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PTR = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_INSN = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_LOCKS = 8'h18;
  localparam logic [7:0] ADDR_BUFRD = 8'h1c;
  localparam int BIT_STORE_EN = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_REEN = 4;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
  localparam logic [15:0] PTR_FUSE_HI = 16'h0003;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam int PROG_TIME_US = 4500;
  localparam int CLK_MHZ = 50;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG = 2'b11,
    ST_DONE = 2'b10
  } seq_state_t;
  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } bus_req_t;
endpackage : flash_seq_pkg

// file: rtl/page_buffer.sv
// Temporary page buffer of the flash sequencer with per-word valid bits.
// Assumes a single clock; clear wins over a same-cycle load.
`timescale 1ns/1ps
`default_nettype none
module page_buffer #(
  parameter int WORDS = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [$clog2(WORDS)-1:0] load_idx_i,
  input wire logic [15:0] load_data_i,
  input wire logic [$clog2(WORDS)-1:0] rd_idx_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic any_valid_o
);
  initial begin
    if (WORDS < 2) begin
      $error("page_buffer needs at least two words");
    end
  end

  logic [15:0] mem_q [WORDS];
  logic [WORDS-1:0] valid_q;

  // Unloaded words read as erased flash.
  assign rd_valid_o = valid_q[rd_idx_i];
  assign any_valid_o = |valid_q;

  always_ff @(posedge clk_i) begin
    if (load_i) begin
      mem_q[load_idx_i] <= load_data_i;
    end
    rd_data_o <= valid_q[rd_idx_i] ? mem_q[rd_idx_i] : 16'hffff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      valid_q <= '0;
    end else if (load_i) begin
      valid_q[load_idx_i] <= 1'b1;
    end
  end
endmodule : page_buffer
`default_nettype wire

// file: dv/eeprom_writer.sv
// Model of the EEPROM block beside the sequencer: holds write-active high for a set time.
// Assumes the sequencer's clock and a one-cycle start pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module eeprom_writer #(
  parameter int LEN = 30
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o
);
  int cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_q <= 0;
    else if (start_i) cnt_q <= LEN;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
  end
  assign busy_o = (cnt_q > 0);
endmodule : eeprom_writer
`default_nettype wire

// file: dv/flash_self_program_sequencer_tb.sv
// Self-checking bench for the self-programming sequencer, driven over its Wishbone port.
// Assumes the EEPROM model in eeprom_writer and a programming time cut to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_tb;
  localparam logic [7:0] FL = 8'h5a;
  localparam logic [7:0] FH = 8'h3c;
  localparam logic [7:0] A_CTL = flash_seq_pkg::ADDR_CTRL;
  localparam logic [7:0] A_PTR = flash_seq_pkg::ADDR_PTR;
  logic clk_i, rst_i, cyc, stb, we, ee_start, ee_busy, ack_o, halt, blk, irq, ep, wp;
  logic [7:0] adr, lock_m;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, rd, seed;
  logic [6:0] pg, page, hp;
  logic [15:0] ld_q [$];
  int err_count, tests_run, erase_n = 0, write_n = 0;
  flash_self_program_sequencer #(.PROG_CYCLES(20), .FUSE_LOW(FL), .FUSE_HIGH(FH)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .eeprom_write_active_i(ee_busy),
    .core_halt_o(halt), .section_read_block_o(blk), .ready_irq_o(irq),
    .erase_pulse_o(ep), .write_pulse_o(wp), .prog_page_o(pg));
  eeprom_writer #(.LEN(40)) ee (.clk_i(clk_i), .rst_i(rst_i), .start_i(ee_start), .busy_o(ee_busy));
  always @(posedge clk_i) begin
    if (ep === 1'b1) erase_n <= erase_n + 1;
    if (wp === 1'b1) write_n <= write_n + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; holds the request until ack is sampled high.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      report_and_stop();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Pointer and data go first so that the instruction lands three edges after the arm.
  task automatic op(input logic [4:0] c, input logic [15:0] p, input logic [15:0] d, input logic [1:0] ins);
    wb(A_PTR, 1'b1, {16'h0, p});
    wb(flash_seq_pkg::ADDR_DATA, 1'b1, {16'h0, d});
    wb(A_CTL, 1'b1, {27'h0, c});
    wb(flash_seq_pkg::ADDR_INSN, 1'b1, {30'h0, ins});
  endtask : op
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100) begin
      wb(A_CTL, 1'b0, 32'h0);
      n++;
    end
    if (n >= 100) begin
      err_count++;
      report_and_stop();
    end
  endtask : wait_idle
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; sel = 4'hf;
    ee_start = 1'b0; err_count = 0; tests_run = 0; seed = 32'h63; lock_m = 8'hff;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({halt, blk, irq, pg}, 32'h0);
    wb(flash_seq_pkg::ADDR_LOCKS, 1'b0, 32'h0);
    chk(rd, {24'h0, lock_m});
    wb(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    seed = xs(seed);
    page = 7'(seed % 96);
    op(flash_seq_pkg::CMD_ERASE, {3'h0, page, 6'h0}, 16'(seed), 2'h1);
    chk({erase_n[22:0], halt, blk, pg}, {23'h1, 2'b01, page});
    wb(A_PTR, 1'b1, ~seed);
    chk(pg, page);
    wb(A_CTL, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    wait_idle();
    chk(blk, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      ld_q.push_back(16'(seed));
      op(flash_seq_pkg::CMD_LOAD, {3'h0, page, 5'(7 * i + 3), 1'b0}, 16'(seed), 2'h1);
      chk({blk, erase_n[14:0], write_n[15:0]}, {1'b0, 15'h1, 16'h0});
      wb(A_CTL, 1'b0, 32'h0);
      chk(rd[0], 1'b0);
    end
    // Read back in the reverse of the load order.
    for (int i = 3; i >= 0; i--) begin
      wb(A_PTR, 1'b1, {16'h0, 3'h0, page, 5'(7 * i + 3), 1'b0});
      wb(flash_seq_pkg::ADDR_BUFRD, 1'b0, 32'h0);
      chk(rd, {15'h0, 1'b1, ld_q[i]});
    end
    for (int h = 0; h < 2; h++) begin
      seed = xs(seed);
      hp = (h == 0) ? 7'(96 + seed % 32) : page;
      if (h == 0) begin
        op(flash_seq_pkg::CMD_ERASE, {3'h0, hp, 6'h0}, 16'h0, 2'h1);
        wait_idle();
      end
      op(flash_seq_pkg::CMD_WRITE, {3'h0, hp, 6'h0}, 16'h0, 2'h1);
      chk({write_n[14:0], halt, blk, pg}, {15'(h + 1), h == 0, h == 1, hp});
      wait_idle();
      chk(halt, 1'b0);
      wb(A_PTR, 1'b1, {16'h0, 3'h0, hp, 5'h3, 1'b0});
      wb(flash_seq_pkg::ADDR_BUFRD, 1'b0, 32'h0);
      chk(rd, 32'h0000_ffff);
    end
    op(flash_seq_pkg::CMD_REEN, 16'h0, 16'h0, 2'h1);
    chk(blk, 1'b0);
    seed = xs(seed);
    op(flash_seq_pkg::CMD_LOCK, flash_seq_pkg::PTR_LOCK, 16'(seed) | 16'h00c3, 2'h1);
    lock_m = lock_m & (seed[7:0] | 8'hc3);
    chk({halt, blk}, 32'h0);
    wait_idle();
    wb(flash_seq_pkg::ADDR_LOCKS, 1'b0, 32'h0);
    chk(rd, {24'h0, lock_m});
    for (int k = 0; k < 3; k++) begin
      op(flash_seq_pkg::CMD_LOCK, 16'(k + k / 2), 16'h0, 2'h2);
      wb(flash_seq_pkg::ADDR_RESULT, 1'b0, 32'h0);
      chk(rd[7:0], (k == 0) ? FL : (k == 1) ? lock_m : FH);
      wb(A_CTL, 1'b0, 32'h0);
      chk(rd[4:0], 5'h0);
    end
    // A load on the fourth armed cycle is too late for a lock read.
    wb(A_PTR, 1'b1, {16'h0, flash_seq_pkg::PTR_LOCK});
    wb(A_CTL, 1'b1, {27'h0, flash_seq_pkg::CMD_LOCK});
    @(posedge clk_i);
    wb(flash_seq_pkg::ADDR_INSN, 1'b1, 32'h2);
    wb(flash_seq_pkg::ADDR_RESULT, 1'b0, 32'h0);
    chk(rd[7:0], FH);
    for (int c = 0; c < 30; c += 6) begin
      op(5'(c + 7), 16'h0, 16'h0, 2'h1);
      wb(A_CTL, 1'b0, 32'h0);
      chk({rd[4:0], erase_n[12:0], write_n[13:0]}, {5'h0, 13'h2, 14'h2});
    end
    wb(A_CTL, 1'b1, 32'h1);
    repeat (6) @(posedge clk_i);
    wb(A_CTL, 1'b0, 32'h0);
    chk(rd[0], 1'b0);
    seed = xs(seed);
    op(flash_seq_pkg::CMD_LOAD, 16'h0, 16'(seed), 2'h1);
    wb(flash_seq_pkg::ADDR_BUFRD, 1'b0, 32'h0);
    chk(rd, {15'h0, 1'b1, 16'(seed)});
    ee_start <= 1'b1;
    @(posedge clk_i);
    ee_start <= 1'b0;
    op(flash_seq_pkg::CMD_ERASE, 16'h0, 16'h0, 2'h1);
    wb(A_CTL, 1'b0, 32'h0);
    chk({rd[4:0], erase_n[25:0], ee_busy}, {5'h0, 26'h2, 1'b1});
    wb(flash_seq_pkg::ADDR_BUFRD, 1'b0, 32'h0);
    chk(rd, 32'h0000_ffff);
    op(flash_seq_pkg::CMD_LOCK, flash_seq_pkg::PTR_LOCK, 16'h0, 2'h2);
    wb(flash_seq_pkg::ADDR_RESULT, 1'b0, 32'h0);
    chk({rd[7:0], ee_busy}, {FH, 1'b1});
    for (int n = 0; n < 60 && ee_busy; n++) @(posedge clk_i);
    chk(ee_busy, 1'b0);
    wb(A_CTL, 1'b1, 32'h80);
    chk(irq, 1'b1);
    wb(A_CTL, 1'b1, 32'h81);
    chk(irq, 1'b0);
    repeat (6) @(posedge clk_i);
    chk(irq, 1'b1);
    report_and_stop();
  end
endmodule : flash_self_program_sequencer_tb
`default_nettype wire
